// >>> src/usb_frame_pkg.sv
// Shared constants for the frame timer and root port logic
package usb_frame_pkg;

  // ------------------------------------------------------------
  // Register offsets from the I/O base
  // ------------------------------------------------------------
  localparam logic [7:0] host_command_register_off = 8'h00;
  localparam logic [7:0] sof_timing_adjust_off = 8'h0c;
  localparam logic [7:0] root_port0_control_status_off = 8'h10;
  localparam logic [7:0] root_port1_control_status_off = 8'h12;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [6:0] sof_value_reset = 7'h40;
  localparam logic [15:0] port_status_reset = 16'h0080;
  localparam logic [1:0] line_status_reset = 2'h0;

  // ------------------------------------------------------------
  // Command register fields
  // ------------------------------------------------------------
  localparam int cmd_run_bit = 0;
  localparam int cmd_hc_reset_bit = 1;
  localparam int cmd_global_reset_bit = 2;
  localparam int cmd_global_suspend_bit = 3;

  // ------------------------------------------------------------
  // Port control and status fields
  // ------------------------------------------------------------
  localparam int ps_connected_bit = 0;
  localparam int ps_connect_change_bit = 1;
  localparam int ps_enabled_bit = 2;
  localparam int ps_enable_change_bit = 3;
  localparam int ps_line_lo_bit = 4;
  localparam int ps_resume_bit = 6;
  localparam int ps_fixed_one_bit = 7;
  localparam int ps_low_speed_bit = 8;
  localparam int ps_port_reset_bit = 9;
  localparam int ps_suspend_bit = 12;

  // ------------------------------------------------------------
  // Frame timing
  // ------------------------------------------------------------
  localparam logic [13:0] sof_base_length = 14'h2ea0;  // 11936 counter clocks
  localparam int frame_number_width = 11;
  localparam int frame_index_width = 10;

  // ------------------------------------------------------------
  // Attach settling: 64 USB bit times at 12 Mbit/s, 40 ns clock
  // ------------------------------------------------------------
  localparam longint usb_bit_time_ps = 83333;
  localparam longint attach_bit_times = 64;
  localparam longint clock_period_ps = 40000;
  localparam longint attach_time_ps = attach_bit_times * usb_bit_time_ps;
  localparam int attach_cycles_raw = int'(attach_time_ps / clock_period_ps);
  localparam int attach_cycles = (attach_cycles_raw < 1) ? 1 : attach_cycles_raw;
  localparam logic [7:0] attach_cycles_last = 8'(attach_cycles - 1);

endpackage

// >>> src/sof_frame_timer.sv
// Start-of-frame counter and frame number counter
`timescale 1ns/1ns
module sof_frame_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic sof_tick,
  input wire logic [6:0] sof_value,
  // Frame outputs
  output logic sof_strobe,
  output logic [10:0] frame_number
);

  typedef struct packed {
    logic [13:0] count;
    logic [6:0] active_value;
    logic [10:0] frame;
    logic strobe;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;
  logic [13:0] frame_last;

  // Length fixed at the boundary, so mid-frame writes only touch the next frame
  assign frame_last = usb_frame_pkg::sof_base_length + {7'h00, s.active_value} - 14'h0001;

  always_comb begin
    next_s = s;
    next_s.strobe = 1'b0;
    if (run && sof_tick) begin
      if (s.count == frame_last) begin
        next_s.count = 14'h0000;
        next_s.active_value = sof_value;
        next_s.frame = s.frame + 11'h001;
        next_s.strobe = 1'b1;
      end else begin
        next_s.count = s.count + 14'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s.count <= 14'h0000;
      s.active_value <= usb_frame_pkg::sof_value_reset;
      s.frame <= 11'h000;
      s.strobe <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign sof_strobe = s.strobe;
  assign frame_number = s.frame;

endmodule

// >>> src/usb_frame_port_init.sv
// Frame timing adjust, command and root port status logic of a USB host controller
`timescale 1ns/1ns
module usb_frame_port_init #(
  parameter int num_ports = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // I/O register access, offsets from the base
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_offset,
  input wire logic [1:0] io_byte_en,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // SOF counter clock, one pulse per 12 MHz period
  input wire logic sof_tick,
  // Root port line side
  input wire logic [1:0] device_present,
  input wire logic [1:0] device_low_speed,
  input wire logic [3:0] line_state,
  input wire logic [1:0] k_state_seen,
  output logic [1:0] port_enabled,
  output logic [1:0] port_reset_drive,
  output logic [1:0] resume_drive,
  // Frame and suspend status
  output logic sof_strobe,
  output logic [10:0] frame_number,
  output logic [9:0] frame_list_index,
  output logic global_suspend,
  output logic global_resume
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (num_ports != 2) begin : g_bad_ports
    $error("num_ports must be 2: the register map holds two port words");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic connected;
    logic connect_change;
    logic enabled;
    logic enable_change;
    logic [1:0] line_status;
    logic resume;
    logic low_speed;
    logic port_reset;
    logic suspend;
    logic [7:0] attach_count;
  } port_state_t;

  typedef struct packed {
    logic run;
    logic hc_reset;
    logic global_reset;
    logic suspend;
    logic resume_signal;
    logic [6:0] sof_value;
    logic [15:0] rdata;
    port_state_t [1:0] ports;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic any_reset;
  logic timer_reset;

  // Full word write check, decoded for both ports
  function automatic logic word_write(input logic wr, input logic [7:0] off,
                                      input logic [7:0] target, input logic [1:0] be);
    word_write = wr && (off == target) && (be == 2'b11);
  endfunction

  function automatic logic [15:0] port_word(input port_state_t p);
    logic [15:0] w;
    w = 16'h0000;
    w[usb_frame_pkg::ps_connected_bit] = p.connected;
    w[usb_frame_pkg::ps_connect_change_bit] = p.connect_change;
    w[usb_frame_pkg::ps_enabled_bit] = p.enabled;
    w[usb_frame_pkg::ps_enable_change_bit] = p.enable_change;
    w[usb_frame_pkg::ps_line_lo_bit +: 2] = p.line_status;
    w[usb_frame_pkg::ps_resume_bit] = p.resume;
    w[usb_frame_pkg::ps_fixed_one_bit] = 1'b1;
    w[usb_frame_pkg::ps_low_speed_bit] = p.low_speed;
    w[usb_frame_pkg::ps_port_reset_bit] = p.port_reset;
    w[usb_frame_pkg::ps_suspend_bit] = p.suspend;
    port_word = w;
  endfunction

  // Host controller reset is one cycle; global reset holds while its bit is set
  assign any_reset = rst || s.hc_reset || s.global_reset;
  assign timer_reset = any_reset;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] port_off;
    logic wr_port;
    logic rise;
    next_s = s;
    port_off = 8'h00;
    wr_port = 1'b0;
    rise = 1'b0;
    next_s.hc_reset = 1'b0;

    // Command register
    if (io_write && io_offset == usb_frame_pkg::host_command_register_off && io_byte_en[0]) begin
      next_s.run = io_wdata[usb_frame_pkg::cmd_run_bit];
      next_s.hc_reset = io_wdata[usb_frame_pkg::cmd_hc_reset_bit];
      next_s.global_reset = io_wdata[usb_frame_pkg::cmd_global_reset_bit];
      next_s.suspend = io_wdata[usb_frame_pkg::cmd_global_suspend_bit];
    end

    // Adjust register, byte wide; bit 7 dropped
    if (io_write && io_offset == usb_frame_pkg::sof_timing_adjust_off && io_byte_en[0]) begin
      next_s.sof_value = io_wdata[6:0];
    end

    for (int i = 0; i < 2; i++) begin
      port_off = (i == 0) ? usb_frame_pkg::root_port0_control_status_off
                          : usb_frame_pkg::root_port1_control_status_off;
      wr_port = word_write(io_write, io_offset, port_off, io_byte_en);

      // Software side first, so hardware sets below win over clears
      if (wr_port) begin
        if (io_wdata[usb_frame_pkg::ps_connect_change_bit]) begin
          next_s.ports[i].connect_change = 1'b0;
        end
        if (io_wdata[usb_frame_pkg::ps_enable_change_bit]) begin
          next_s.ports[i].enable_change = 1'b0;
        end
        next_s.ports[i].enabled = io_wdata[usb_frame_pkg::ps_enabled_bit] && s.ports[i].connected;
        next_s.ports[i].resume = io_wdata[usb_frame_pkg::ps_resume_bit];
        next_s.ports[i].port_reset = io_wdata[usb_frame_pkg::ps_port_reset_bit];
        next_s.ports[i].suspend = io_wdata[usb_frame_pkg::ps_suspend_bit];
      end

      // Attach filter: presence must hold for the settling time
      if (device_present[i] != s.ports[i].connected) begin
        if (s.ports[i].attach_count == usb_frame_pkg::attach_cycles_last) begin
          next_s.ports[i].attach_count = 8'h00;
          next_s.ports[i].connected = device_present[i];
          next_s.ports[i].connect_change = 1'b1;
          next_s.ports[i].low_speed = device_present[i] && device_low_speed[i];
        end else begin
          next_s.ports[i].attach_count = s.ports[i].attach_count + 8'h01;
        end
      end else begin
        next_s.ports[i].attach_count = 8'h00;
      end

      // Loss of device, or port reset, drops the enable
      if (!next_s.ports[i].connected || next_s.ports[i].port_reset) begin
        if (s.ports[i].enabled) begin
          next_s.ports[i].enable_change = 1'b1;
        end
        next_s.ports[i].enabled = 1'b0;
      end

      // Remote wakeup seen while the port is suspended
      if (s.ports[i].suspend && k_state_seen[i]) begin
        next_s.ports[i].resume = 1'b1;
      end

      // Line status only shows a connected port; SE0 otherwise
      next_s.ports[i].line_status = next_s.ports[i].connected ? line_state[2 * i +: 2]
                                                              : usb_frame_pkg::line_status_reset;

      rise = rise
        || (next_s.ports[i].resume && !s.ports[i].resume)
        || (next_s.ports[i].enable_change && !s.ports[i].enable_change)
        || (next_s.ports[i].connect_change && !s.ports[i].connect_change);
    end

    // Resume signalling only in global suspend, held until software leaves it
    if (!next_s.suspend) begin
      next_s.resume_signal = 1'b0;
    end else if (s.suspend && rise) begin
      next_s.resume_signal = 1'b1;
    end

    // Read data registered, answer one cycle after io_read
    next_s.rdata = 16'h0000;
    if (io_read) begin
      case (io_offset)
        usb_frame_pkg::host_command_register_off: begin
          next_s.rdata = {12'h000, s.suspend, s.global_reset, 1'b0, s.run};
        end
        usb_frame_pkg::sof_timing_adjust_off: begin
          next_s.rdata = {9'h000, s.sof_value};
        end
        usb_frame_pkg::root_port0_control_status_off: begin
          next_s.rdata = port_word(s.ports[0]);
        end
        usb_frame_pkg::root_port1_control_status_off: begin
          next_s.rdata = port_word(s.ports[1]);
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (any_reset) begin
      s.run <= 1'b0;
      s.hc_reset <= 1'b0;
      s.suspend <= 1'b0;
      s.resume_signal <= 1'b0;
      s.sof_value <= usb_frame_pkg::sof_value_reset;
      s.rdata <= 16'h0000;
      s.ports <= '0;
      // Global reset bit is software's own; only a full reset or a write clears it
      if (rst) begin
        s.global_reset <= 1'b0;
      end else begin
        s.global_reset <= next_s.global_reset;
      end
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Frame timer
  // ------------------------------------------------------------
  sof_frame_timer u_timer (
    .clock(clock),
    .rst(timer_reset),
    .run(s.run),
    .sof_tick(sof_tick),
    .sof_value(s.sof_value),
    .sof_strobe(sof_strobe),
    .frame_number(frame_number)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign io_rdata = s.rdata;
  assign frame_list_index = frame_number[9:0];
  assign global_suspend = s.suspend;
  assign global_resume = s.resume_signal;
  assign port_enabled = {s.ports[1].enabled, s.ports[0].enabled};
  assign port_reset_drive = {s.ports[1].port_reset, s.ports[0].port_reset};
  assign resume_drive = {s.ports[1].resume && s.ports[1].suspend,
                         s.ports[0].resume && s.ports[0].suspend};

endmodule

// >>> testbench/frame_port_sva.sv
// Assertions on the frame timer and root port outputs
`timescale 1ns/1ns
module frame_port_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Observed ports
  input wire logic io_write,
  input wire logic [1:0] port_enabled,
  input wire logic [1:0] port_reset_drive,
  input wire logic sof_strobe,
  input wire logic [10:0] frame_number,
  input wire logic [9:0] frame_list_index,
  input wire logic global_suspend,
  input wire logic global_resume
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----
  // Frame timer
  // ----
  property p_sof_pulse;
    sof_strobe |=> !sof_strobe;
  endproperty
  a_sof_pulse: assert property (p_sof_pulse) else $error("frame strobe too long");
  property p_frame_inc;
    sof_strobe |-> frame_number == 11'($past(frame_number) + 11'h001);
  endproperty
  a_frame_inc: assert property (p_frame_inc) else $error("frame number skipped");
  // Resets launched by a command write also move the count
  property p_frame_hold;
    !sof_strobe && !$past(io_write) && !$past(io_write, 2) |-> $stable(frame_number);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame number moved");
  property p_index;
    frame_list_index == frame_number[9:0];
  endproperty
  a_index: assert property (p_index) else $error("frame index differs");
  // ----
  // Suspend and ports
  // ----
  property p_resume_cause;
    $rose(global_resume) |-> $past(global_suspend);
  endproperty
  a_resume_cause: assert property (p_resume_cause) else $error("resume outside suspend");
  property p_resume_hold;
    global_resume && !io_write && !$past(io_write) |=> global_resume;
  endproperty
  a_resume_hold: assert property (p_resume_hold) else $error("resume dropped");
  property p_suspend_cmd;
    $changed(global_suspend) |-> $past(io_write) || $past(io_write, 2);
  endproperty
  a_suspend_cmd: assert property (p_suspend_cmd) else $error("suspend moved alone");
  property p_reset_disables;
    port_reset_drive[0] |-> !port_enabled[0];
  endproperty
  a_reset_disables: assert property (p_reset_disables) else $error("enabled in reset");
  property p_enable_write;
    $rose(port_enabled[0]) |-> $past(io_write);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable without write");
  c_sof: cover property (sof_strobe);
  c_resume: cover property ($rose(global_resume));
  c_enable: cover property ($rose(port_enabled[0]));
endmodule

bind usb_frame_port_init frame_port_sva chk (
  .clock, .rst, .io_write, .port_enabled, .port_reset_drive, .sof_strobe,
  .frame_number, .frame_list_index, .global_suspend, .global_resume
);

// >>> testbench/usb_device_model.sv
// Behavioural model of the devices on the two root ports
`timescale 1ns/1ns
module usb_device_model (
  // Bench control
  input wire logic [1:0] attach,
  input wire logic [1:0] slow,
  input wire logic [1:0] wake,
  // Port line side
  output logic [1:0] device_present,
  output logic [1:0] device_low_speed,
  output logic [3:0] line_state,
  output logic [1:0] k_state_seen
);
  // Detached lines fall to SE0 through the host pull-downs
  always_comb begin
    device_present = attach;
    device_low_speed = attach & slow;
    k_state_seen = attach & wake;
    for (int i = 0; i < 2; i++) begin
      line_state[2*i +: 2] = !attach[i] ? 2'h0 : (slow[i] ? 2'h2 : 2'h1);
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the frame timer and root port logic
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] cmd = usb_frame_pkg::host_command_register_off;
  localparam logic [7:0] adj = usb_frame_pkg::sof_timing_adjust_off;
  localparam logic [7:0] p0 = usb_frame_pkg::root_port0_control_status_off;
  localparam logic [7:0] p1 = usb_frame_pkg::root_port1_control_status_off;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic io_write = 1'b0;
  logic io_read = 1'b0;
  logic [7:0] io_offset = 8'h00;
  logic [1:0] io_byte_en = 2'h0;
  logic [15:0] io_wdata = 16'h0000;
  logic sof_tick = 1'b0;
  logic [1:0] attach = 2'h0;
  logic [1:0] slow = 2'h0;
  logic [1:0] wake = 2'h0;
  logic [15:0] io_rdata, rd;
  logic [1:0] device_present, device_low_speed, k_state_seen, port_enabled;
  logic [1:0] port_reset_drive, resume_drive;
  logic [3:0] line_state;
  logic sof_strobe, global_suspend, global_resume;
  logic [10:0] frame_number;
  logic [9:0] frame_list_index;
  logic [6:0] sw_copy = 7'h40;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ns = 0;
  int st[8];

  usb_frame_port_init DUT (
    .clock, .rst, .io_write, .io_read, .io_offset, .io_byte_en, .io_wdata, .io_rdata,
    .sof_tick, .device_present, .device_low_speed, .line_state, .k_state_seen,
    .port_enabled, .port_reset_drive, .resume_drive, .sof_strobe, .frame_number,
    .frame_list_index, .global_suspend, .global_resume
  );
  usb_device_model devices (
    .attach, .slow, .wake, .device_present, .device_low_speed, .line_state, .k_state_seen
  );

  initial begin
    forever #20 clock = ~clock;
  end

  // ----
  // Strobe log and hang limit
  // ----
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (sof_strobe === 1'b1 && ns < 8) begin
      st[ns] <= cyc;
      ns <= ns + 1;
    end
    if (cyc == 60000) begin
      failures = failures + 1;
      results();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic io_wr(input logic [7:0] off, input logic [1:0] be, input logic [15:0] d);
    @(negedge clock);
    io_write = 1'b1;
    io_offset = off;
    io_byte_en = be;
    io_wdata = d;
    @(negedge clock);
    io_write = 1'b0;
  endtask

  // Read data stands for one cycle only, so it is taken at the next falling edge
  task automatic rd_chk(input logic [7:0] off, input logic [15:0] exp);
    @(negedge clock);
    io_read = 1'b1;
    io_offset = off;
    @(negedge clock);
    io_read = 1'b0;
    rd = io_rdata;
    chk_word(rd, exp);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rd_chk(adj, 16'h0040);
    rd_chk(p0, 16'h0080);
    rd_chk(p1, 16'h0080);
    rd_chk(8'h20, 16'h0000);
    chk_word({14'h0, port_enabled}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_adjust;
    io_wr(adj, 2'h1, 16'h00ff);
    rd_chk(adj, 16'h007f);
    io_wr(cmd, 2'h1, 16'h0002);
    repeat (2) @(negedge clock);
    rd_chk(adj, 16'h0040);
    io_wr(adj, 2'h1, 16'h0011);
    sw_copy = 7'h11;
    io_wr(cmd, 2'h1, 16'h0004);
    io_wr(cmd, 2'h1, 16'h0000);
    rd_chk(adj, 16'h0040);
    rd_chk(p0, 16'h0080);
    io_wr(adj, 2'h1, {9'h0, sw_copy});
    rd_chk(adj, 16'h0011);
    $display("test adjust done");
  endtask

  task automatic t_attach;
    @(negedge clock);
    attach = 2'h3;
    slow = 2'h1;
    repeat (100) @(negedge clock);
    rd_chk(p0, 16'h0080);
    repeat (40) @(negedge clock);
    rd_chk(p0, 16'h01a3);
    rd_chk(p1, 16'h0093);
    io_wr(p0, 2'h3, 16'h0002);
    rd_chk(p0, 16'h01a1);
    io_wr(p0, 2'h1, 16'h0004);
    rd_chk(p0, 16'h01a1);
    io_wr(p0, 2'h3, 16'h0004);
    chk_word({14'h0, port_enabled}, 16'h0001);
    io_wr(p0, 2'h3, 16'h0204);
    rd_chk(p0, 16'h03a9);
    chk_word({12'h0, port_reset_drive, port_enabled}, 16'h0004);
    $display("test attach done");
  endtask

  task automatic t_resume;
    // Port 0 suspended before global suspend, so wakeup can reach it
    io_wr(p0, 2'h3, 16'h1000);
    io_wr(cmd, 2'h1, 16'h0008);
    chk_word({14'h0, global_suspend, global_resume}, 16'h0002);
    io_wr(p1, 2'h3, 16'h0040);
    @(negedge clock);
    chk_word({15'h0, global_resume}, 16'h0001);
    wake = 2'h1;
    rd_chk(p0, 16'h11e9);
    chk_word({14'h0, resume_drive}, 16'h0001);
    wake = 2'h0;
    io_wr(cmd, 2'h1, 16'h0000);
    @(negedge clock);
    chk_word({14'h0, global_suspend, global_resume}, 16'h0000);
    $display("test resume done");
  endtask

  // One tick per clock keeps a frame at its length in clock cycles
  task automatic t_frame;
    @(negedge clock);
    sof_tick = 1'b1;
    io_wr(cmd, 2'h1, 16'h0001);
    for (int i = 0; i < 12100 && ns < 1; i++) @(negedge clock);
    io_wr(adj, 2'h1, 16'h0000);
    for (int i = 0; i < 12100 && ns < 2; i++) @(negedge clock);
    io_wr(adj, 2'h1, 16'h007f);
    for (int i = 0; i < 24200 && ns < 4; i++) @(negedge clock);
    // Second frame uses the value restored from the software copy
    chk_word(16'(st[1] - st[0]), 16'h2ea0 + {9'h0, sw_copy});
    chk_word(16'(st[2] - st[1]), 16'h2ea0);
    chk_word(16'(st[3] - st[2]), 16'h2f1f);
    chk_word({5'h0, frame_number}, 16'h0004);
    chk_word({6'h0, frame_list_index}, 16'h0004);
    $display("test frame done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_adjust();
    t_attach();
    t_resume();
    t_frame();
    results();
  end
endmodule
